/* File: common/command_link_pkg.sv */
// Shared constants, symbol codes and check word function for the command link.
// Functional notes
// [RL1] Board logic runs on the aggregator's clock.
// [RL2] Fast signals travel without channel coding.
// [RL3] Fast frame: comma high byte, command low.
// [RL4] Symbol X.Y is five bits X, three Y.
// [RL5] Block length is always an even word count; the code accepts any length up to 16 words, odd ones included.
// [RL6] Block: type, sequence, selector, length, data, check.
// [RL7] Type bits: data, command, link, firmware.
// [RL8] Type bits pick one of three subsystems.
// [RL9] Card identifier only in type's top four bits.
// [RL10] Sender numbers blocks consecutively for loss detection.
// [RL11] Selector field addresses the target command register.
// [RL12] Receiver checks each block's trailing check word.
// [RL13] Comma 28.0 announces a sync command word.
// [RL14] Comma 28.3 announces an ordinary command word.
// [RL15] Comma 28.4 announces a board-link command word.
// [RL16] Commas 28.5, 28.7 never prefix commands.
// [RL17] Carrier extend pads frame to even symbols.
// [RL18] Comma 27.7 starts, 29.7 ends a frame.
// [RL19] Idle pairs between frames, chosen by disparity.
// [RL20] Frame ends: end symbol, one or two extends.
// [RL21] Loopback and bring-up sequences never from user.
// [RL22] Direct host link uses same framing, uncoded.
// [RL23] Fast command register chosen by word's X.
// [RL24] Failed check: no register update, flag error.
package command_link_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int LINK_PERIOD_NS  = 160;
	localparam int LINK_DIV_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int LINK_HALF       = LINK_DIV_CYCLES / 2;

	// ==========================================================
	// Symbols, written as {X[4:0], Y[2:0]}
	localparam logic [7:0] K_SYNC_CMD  = 8'he0; // 28.0
	localparam logic [7:0] K_COMMAND   = 8'he3; // 28.3
	localparam logic [7:0] K_LINK_CMD  = 8'he4; // 28.4
	localparam logic [7:0] K_LINK_SYNC = 8'he5; // 28.5
	localparam logic [7:0] K_LINK_RSV  = 8'he7; // 28.7
	localparam logic [7:0] K_EXTEND    = 8'hbf; // 23.7
	localparam logic [7:0] K_FRAME_SOF = 8'hdf; // 27.7
	localparam logic [7:0] K_FRAME_EOF = 8'hef; // 29.7
	localparam logic [7:0] D_IDLE_FLIP = 8'h2e; // 5.6
	localparam logic [7:0] D_IDLE_KEEP = 8'h82; // 16.2
	localparam logic [7:0] D_LOOP_BEGIN        = 8'h66; // 12.6
	localparam logic [7:0] D_LOOPBACK_FINISH   = 8'h87; // 16.7
	localparam logic [7:0] D_LINK_BRINGUP      = 8'h0c; // 1.4
	localparam logic [7:0] D_LINK_BRINGUP_ACK  = 8'hf3; // 30.3
	localparam int SYM_X_LSB = 3;
	localparam int SYM_X_MSB = 7;

	// ==========================================================
	// Fast command kinds
	typedef enum logic [1:0] {
		KIND_SYNC    = 2'h0,
		KIND_COMMAND = 2'h1,
		KIND_LINK    = 2'h2
	} fast_kind_t;

	// ==========================================================
	// Block layout and packet type bits
	localparam logic [15:0] HDR_WORDS       = 16'h0004;
	localparam logic [16:0] BLK_OVERHEAD    = 17'h00005;
	localparam logic [15:0] TYPE_BLOCK_DATA = 16'h0001;
	localparam logic [15:0] TYPE_GENERIC    = 16'h0002;
	localparam logic [15:0] TYPE_SUBSYS_1   = 16'h0010;
	localparam logic [15:0] TYPE_SUBSYS_2   = 16'h0020;
	localparam logic [15:0] TYPE_SUBSYS_3   = 16'h0040;
	localparam logic [15:0] TYPE_LINK       = 16'h0080;
	localparam logic [15:0] TYPE_FIRMWARE   = 16'h0100;
	localparam logic [15:0] TYPE_CARD_MASK  = 16'hf000;
	localparam int          CARD_LSB        = 12;
	localparam int          FIFO_DEPTH      = 16;
	localparam int          WORD_W          = 16;

	// ==========================================================
	// Check word: 16-bit polynomial, seeded with all ones
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;

	function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 15; i >= 0; i--) begin
			if (r[15] ^ d[i]) begin
				r = {r[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

endpackage

/* File: common/command_link_if.sv */
// Command link wires between the aggregator end and the board end.
`timescale 1ns/1ns
interface command_link_if;
	logic       link_clk;
	logic [7:0] down_sym;
	logic       down_k;
	logic       up_mem_full;
	logic       up_busy;
	logic       up_crc_err;

	modport aggregator (
		output link_clk,
		output down_sym,
		output down_k,
		input  up_mem_full,
		input  up_busy,
		input  up_crc_err
	);

	modport board (
		input  link_clk,
		input  down_sym,
		input  down_k,
		output up_mem_full,
		output up_busy,
		output up_crc_err
	);
endinterface

/* File: hw/link_aggregator_end.sv */
// Aggregator end: divides the link clock and frames fast commands and blocks.
`timescale 1ns/1ns
module link_aggregator_end (
	input  wire logic        CLOCK,
	input  wire logic        RSTN,
	command_link_if.aggregator LNK,
	input  wire logic        FAST_REQ,
	input  wire logic [1:0]  FAST_KIND,
	input  wire logic [7:0]  FAST_WORD,
	output logic             FAST_READY,
	input  wire logic        BLK_REQ,
	input  wire logic [15:0] BLK_TYPE,
	input  wire logic [15:0] BLK_SEL,
	input  wire logic [15:0] BLK_LEN,
	output logic             BLK_READY,
	input  wire logic        DATA_VALID,
	input  wire logic [15:0] DATA_WORD,
	output logic             DATA_READY,
	output logic             MEM_FULL,
	output logic             BUSY,
	output logic             CRC_ERROR
);
	typedef enum logic [5:0] {
		H_IDLE_K = 6'h01,
		H_IDLE_D = 6'h02,
		H_FAST_D = 6'h04,
		H_WORD   = 6'h08,
		H_EOF    = 6'h10,
		H_PAD    = 6'h20
	} host_state_t;

	host_state_t state;
	logic [2:0]  div;
	logic        tick;
	logic [7:0]  sym;
	logic        sym_k;
	logic        disp;
	logic        par;
	logic        phase;
	logic [15:0] widx;
	logic [15:0] wreg;
	logic [15:0] crc;
	logic [15:0] seq;
	logic [15:0] b_type;
	logic [15:0] b_sel;
	logic [15:0] b_len;
	logic [7:0]  f_word;
	logic [15:0] cur;
	logic [2:0]  up_s1;
	logic [2:0]  up_s2;
	logic        take_fast;
	logic        take_blk;
	logic        last_word;
	logic        is_data;

	// ==========================================================
	// Link clock divider; symbols change on the falling edge
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			div <= 3'h0;
		end else if (tick) begin
			div <= 3'h0;
		end else begin
			div <= div + 3'h1;
		end
	end

	assign tick         = (div == 3'(command_link_pkg::LINK_DIV_CYCLES - 1));
	assign LNK.link_clk = (div >= 3'(command_link_pkg::LINK_HALF));
	assign LNK.down_sym = sym;
	assign LNK.down_k   = sym_k;

	// ==========================================================
	// Uplink flags come from the far clock domain
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			up_s1 <= 3'h0;
			up_s2 <= 3'h0;
		end else begin
			up_s1 <= {LNK.up_crc_err, LNK.up_busy, LNK.up_mem_full};
			up_s2 <= up_s1;
		end
	end

	assign MEM_FULL  = up_s2[0];
	assign BUSY      = up_s2[1];
	assign CRC_ERROR = up_s2[2];

	// ==========================================================
	// Request acceptance; fast commands win over blocks
	assign FAST_READY = (state == H_IDLE_K) && tick;
	assign take_fast  = FAST_READY && FAST_REQ;
	assign BLK_READY  = FAST_READY && !FAST_REQ && !up_s2[1] && !up_s2[0];
	assign take_blk   = BLK_READY && BLK_REQ;
	assign is_data    = (widx >= command_link_pkg::HDR_WORDS) && ({1'b0, widx} <
		{1'b0, b_len} + 17'(command_link_pkg::HDR_WORDS));
	assign last_word  = ({1'b0, widx} == {1'b0, b_len} + 17'(command_link_pkg::HDR_WORDS));
	assign DATA_READY = (state == H_WORD) && tick && !phase && is_data;

	always_comb begin
		case (widx)
			16'h0000: cur = b_type;
			16'h0001: cur = seq;
			16'h0002: cur = b_sel;
			16'h0003: cur = b_len;
			default:  cur = is_data ? DATA_WORD : crc;
		endcase
	end

	// ==========================================================
	// Symbol sequencer
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			state <= H_IDLE_K;
			sym   <= command_link_pkg::K_LINK_SYNC;
			sym_k <= 1'b1;
			par   <= 1'b0;
			phase <= 1'b0;
			widx  <= 16'h0000;
			wreg  <= 16'h0000;
			crc   <= command_link_pkg::CRC_INIT;
		end else if (tick) begin
			case (state)
				H_IDLE_K: begin
					sym_k <= 1'b1;
					par   <= 1'b1;
					phase <= 1'b0;
					widx  <= 16'h0000;
					crc   <= command_link_pkg::CRC_INIT;
					if (take_fast) begin
						case (FAST_KIND)
							command_link_pkg::KIND_SYNC:    sym <= command_link_pkg::K_SYNC_CMD; // see [RL13]
							command_link_pkg::KIND_LINK:    sym <= command_link_pkg::K_LINK_CMD; // see [RL15]
							default:                        sym <= command_link_pkg::K_COMMAND; // see [RL14]
						endcase
						state <= H_FAST_D;
					end else if (take_blk) begin
						sym   <= command_link_pkg::K_FRAME_SOF; // see [RL18]
						state <= H_WORD;
					end else begin
						sym   <= command_link_pkg::K_LINK_SYNC; // see [RL19]
						state <= H_IDLE_D;
					end
				end
				H_IDLE_D: begin
					sym_k <= 1'b0;
					sym   <= disp ? command_link_pkg::D_IDLE_FLIP : command_link_pkg::D_IDLE_KEEP; // see [RL19]
					state <= H_IDLE_K;
				end
				H_FAST_D: begin
					sym_k <= 1'b0;
					sym   <= f_word; // see [RL3]
					state <= H_IDLE_K;
				end
				H_WORD: begin
					sym_k <= 1'b0;
					par   <= ~par;
					phase <= ~phase;
					if (!phase) begin
						sym  <= cur[15:8];
						wreg <= cur;
					end else begin
						sym  <= wreg[7:0];
						crc  <= command_link_pkg::crc_word(crc, wreg); // see [RL12]
						widx <= widx + 16'h0001;
						if (last_word) begin
							state <= H_EOF;
						end
					end
				end
				H_EOF: begin
					sym_k <= 1'b1;
					sym   <= command_link_pkg::K_FRAME_EOF; // see [RL18] [RL20]
					par   <= ~par;
					state <= H_PAD;
				end
				H_PAD: begin
					sym_k <= 1'b1;
					sym   <= command_link_pkg::K_EXTEND; // see [RL17] [RL20]
					par   <= ~par;
					if (par) begin
						state <= H_IDLE_K;
					end
				end
				default: state <= H_IDLE_K;
			endcase
		end
	end

	// Notional disparity: no coder here, so odd-weight symbols of block words flip it
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			disp <= 1'b0;
		end else if (tick && state == H_IDLE_D) begin
			disp <= 1'b0;
		end else if (tick && !sym_k && state != H_IDLE_K) begin
			disp <= disp ^ (^sym);
		end
	end

	// ==========================================================
	// Latched request fields and block numbering
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			f_word <= 8'h00;
			b_type <= 16'h0000;
			b_sel  <= 16'h0000;
			b_len  <= 16'h0000;
			seq    <= 16'h0000;
		end else begin
			if (take_fast) begin
				f_word <= FAST_WORD;
			end
			if (take_blk) begin
				b_type <= BLK_TYPE; // see [RL7] [RL8] [RL9]
				b_sel  <= BLK_SEL;
				b_len  <= BLK_LEN;
			end
			if (tick && state == H_EOF) begin
				seq <= seq + 16'h0001; // see [RL10]
			end
		end
	end

endmodule // link_aggregator_end

/* File: hw/link_board_end.sv */
// Board end: samples the link, decodes fast commands, checks and buffers blocks.
`timescale 1ns/1ns
module fifo_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr;
	logic [AW:0]      rd;

	assign out_valid = (wr != rd);
	assign in_ready  = (wr != {~rd[AW], rd[AW-1:0]});
	assign out_data  = mem[rd[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			wr <= '0;
			rd <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr <= wr + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd <= rd + 1'b1;
			end
		end
	end
endmodule // fifo_buffer

module link_board_end (
	input  wire logic        CLOCK,
	input  wire logic        RSTN,
	command_link_if.board    LNK,
	input  wire logic        MEMORY_FULL,
	output logic             FAST_VALID,
	output logic [1:0]       FAST_KIND,
	output logic [7:0]       FAST_WORD,
	output logic [4:0]       FAST_ADDR,
	output logic             BLK_VALID,
	input  wire logic        BLK_READY,
	output logic [15:0]      BLK_ADDR,
	output logic [15:0]      BLK_TYPE,
	output logic [15:0]      BLK_DATA,
	output logic             BLK_ERROR,
	output logic             SEQ_GAP
);
	typedef enum logic [3:0] {
		R_IDLE  = 4'h1,
		R_FAST  = 4'h2,
		R_FRAME = 4'h4,
		R_DRAIN = 4'h8
	} rx_state_t;

	rx_state_t   state;
	logic [9:0]  s1;
	logic [9:0]  s2;
	logic        clk_d;
	logic        edge_seen;
	logic [7:0]  sym;
	logic        sym_k;
	logic        phase;
	logic [7:0]  hi;
	logic [15:0] word;
	logic [15:0] widx;
	logic [15:0] last;
	logic [15:0] crc;
	logic [15:0] b_len;
	logic [15:0] b_seq;
	logic [15:0] exp_seq;
	logic        have_seq;
	logic        ovf;
	logic        crc_err;
	logic        push;
	logic        push_ready;
	logic        flush;
	logic        fifo_valid;
	logic        word_done;
	logic        frame_ok;

	// ==========================================================
	// Link sampling: two flops, then edge detect on the second
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			s1    <= 10'h000;
			s2    <= 10'h000;
			clk_d <= 1'b0;
		end else begin
			s1    <= {LNK.link_clk, LNK.down_k, LNK.down_sym}; // see [RL1] [RL22]
			s2    <= s1;
			clk_d <= s2[9];
		end
	end

	assign edge_seen = s2[9] && !clk_d;
	assign sym       = s2[7:0];
	assign sym_k     = s2[8];
	assign word      = {hi, sym};
	assign word_done = edge_seen && state == R_FRAME && !sym_k && phase;
	assign push      = word_done && (widx >= command_link_pkg::HDR_WORDS) && ({1'b0, widx} <
		{1'b0, b_len} + 17'(command_link_pkg::HDR_WORDS));
	// Odd symbol counts or trailing halves fail here as well
	assign frame_ok  = !phase && !ovf && (crc == last) && // see [RL5] [RL12]
		({1'b0, widx} == {1'b0, b_len} + command_link_pkg::BLK_OVERHEAD);
	// Any comma but a clean frame end aborts, so no partial block lingers
	assign flush     = edge_seen && state == R_FRAME && sym_k &&
		!(sym == command_link_pkg::K_FRAME_EOF && frame_ok);
	assign BLK_VALID = fifo_valid && state == R_DRAIN; // see [RL24]

	fifo_buffer #(
		.WIDTH (command_link_pkg::WORD_W),
		.DEPTH (command_link_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (CLOCK),
		.rst_n     (RSTN),
		.flush     (flush),
		.in_valid  (push),
		.in_ready  (push_ready),
		.in_data   (word),
		.out_valid (fifo_valid),
		.out_ready (BLK_READY && state == R_DRAIN),
		.out_data  (BLK_DATA)
	);

	// ==========================================================
	// Receive state machine
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			state <= R_IDLE;
		end else begin
			case (state)
				R_IDLE: begin
					if (edge_seen && sym_k) begin
						case (sym)
							command_link_pkg::K_SYNC_CMD,
							command_link_pkg::K_COMMAND,
							command_link_pkg::K_LINK_CMD:  state <= R_FAST; // see [RL13] [RL14] [RL15]
							command_link_pkg::K_FRAME_SOF: state <= R_FRAME; // see [RL18]
							default:                       state <= R_IDLE; // see [RL16] [RL21]
						endcase
					end
				end
				R_FAST: begin
					if (edge_seen) begin
						state <= R_IDLE;
					end
				end
				R_FRAME: begin
					if (edge_seen && sym_k) begin
						state <= (sym == command_link_pkg::K_FRAME_EOF && frame_ok) ? R_DRAIN : R_IDLE;
					end
				end
				R_DRAIN: begin
					if (!fifo_valid) begin
						state <= R_IDLE;
					end
				end
				default: state <= R_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Fast command decode
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			FAST_VALID <= 1'b0;
			FAST_KIND  <= 2'h0;
			FAST_WORD  <= 8'h00;
			FAST_ADDR  <= 5'h00;
		end else begin
			FAST_VALID <= edge_seen && state == R_FAST && !sym_k; // see [RL3]
			if (edge_seen && state == R_IDLE && sym_k) begin
				case (sym)
					command_link_pkg::K_SYNC_CMD: FAST_KIND <= command_link_pkg::KIND_SYNC;
					command_link_pkg::K_LINK_CMD: FAST_KIND <= command_link_pkg::KIND_LINK;
					default:                      FAST_KIND <= command_link_pkg::KIND_COMMAND;
				endcase
			end
			if (edge_seen && state == R_FAST && !sym_k) begin
				FAST_WORD <= sym;
				FAST_ADDR <= sym[command_link_pkg::SYM_X_MSB:command_link_pkg::SYM_X_LSB]; // see [RL4] [RL23]
			end
		end
	end

	// ==========================================================
	// Block assembly: running check over all words but the newest
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			phase    <= 1'b0;
			hi       <= 8'h00;
			widx     <= 16'h0000;
			last     <= 16'h0000;
			crc      <= command_link_pkg::CRC_INIT;
			b_len    <= 16'h0000;
			b_seq    <= 16'h0000;
			BLK_TYPE <= 16'h0000;
			BLK_ADDR <= 16'h0000;
			ovf      <= 1'b0;
		end else if (edge_seen && state == R_IDLE) begin
			phase <= 1'b0;
			widx  <= 16'h0000;
			crc   <= command_link_pkg::CRC_INIT;
			ovf   <= 1'b0;
		end else if (edge_seen && state == R_FRAME && !sym_k) begin
			phase <= ~phase;
			if (!phase) begin
				hi <= sym;
			end else begin
				widx <= widx + 16'h0001;
				last <= word;
				if (widx != 16'h0000) begin
					crc <= command_link_pkg::crc_word(crc, last); // see [RL12]
				end
				case (widx)
					16'h0000: BLK_TYPE <= word; // see [RL6] [RL7] [RL8] [RL9]
					16'h0001: b_seq    <= word;
					16'h0002: BLK_ADDR <= word; // see [RL11]
					16'h0003: b_len    <= word;
					default:  ovf      <= ovf || (push && !push_ready);
				endcase
			end
		end
	end

	// ==========================================================
	// Block verdict, sequence tracking and uplink flags
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			BLK_ERROR <= 1'b0;
			SEQ_GAP   <= 1'b0;
			crc_err   <= 1'b0;
			have_seq  <= 1'b0;
			exp_seq   <= 16'h0000;
		end else begin
			BLK_ERROR <= flush; // see [RL24]
			SEQ_GAP   <= 1'b0;
			if (flush) begin
				crc_err <= 1'b1;
			end else if (edge_seen && state == R_FRAME && sym_k) begin
				crc_err  <= 1'b0;
				have_seq <= 1'b1;
				exp_seq  <= b_seq + 16'h0001;
				SEQ_GAP  <= have_seq && (b_seq != exp_seq); // see [RL10]
			end
		end
	end

	// Uplink lines are plain levels, never channel coded
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			LNK.up_mem_full <= 1'b0;
			LNK.up_busy     <= 1'b0;
			LNK.up_crc_err  <= 1'b0;
		end else begin
			LNK.up_mem_full <= MEMORY_FULL; // see [RL2]
			LNK.up_busy     <= (state == R_DRAIN) || fifo_valid;
			LNK.up_crc_err  <= crc_err;
		end
	end

endmodule // link_board_end

/* File: tb/command_link_monitor.sv */
// Concurrent checks on the wires between the two link ends.
`timescale 1ns/1ns
module command_link_monitor (
	input wire logic       CLOCK,
	input wire logic       RSTN,
	input wire logic       link_clk,
	input wire logic [7:0] down_sym,
	input wire logic       down_k
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	// ==========================================================
	// Link clock and symbol timing
	a_clk_high_half: assert property ($rose(link_clk) |-> link_clk [*4] ##1 !link_clk)
		else $error("link clock high phase is not four cycles");
	// A fall straight out of reset is the reset's doing, not the divider's
	a_clk_low_half: assert property (
		$fell(link_clk) && $past(RSTN) |-> !link_clk [*4] ##1 link_clk)
		else $error("link clock low phase is not four cycles");
	a_sym_moves_low: assert property ($changed(down_sym) |-> !link_clk)
		else $error("symbol changed while link clock high");
	a_sym_held_high: assert property ($rose(link_clk) |-> $stable(down_sym) [*4])
		else $error("symbol not steady around rising link clock");

	// ==========================================================
	// Framing
	a_comma_then_word: assert property (
		$changed(down_sym) && down_k && down_sym inside {8'he0, 8'he3, 8'he4}
		|-> ##8 !down_k)
		else $error("command comma not followed by a data word");
	a_idle_pair_data: assert property (
		$changed(down_sym) && !down_k && $past(down_k) && $past(down_sym) == 8'he5
		|-> down_sym inside {8'h2e, 8'h82})
		else $error("idle comma followed by a forbidden data symbol");
	a_frame_tail: assert property (
		$changed(down_sym) && down_k && down_sym == 8'hef
		|-> ##8 (down_k && down_sym == 8'hbf) ##8 (down_k && down_sym == 8'hbf))
		else $error("frame end not followed by two extends");
	a_comma_legal: assert property (
		down_k |-> down_sym inside {8'he0, 8'he3, 8'he4, 8'he5, 8'hbf, 8'hdf, 8'hef})
		else $error("illegal comma on the link");
endmodule // command_link_monitor

/* File: tb/test_command_link_framer.sv */
// Self-checking bench joining the aggregator end to the board end.
`timescale 1ns/1ns
module test_command_link_framer;
	logic        clock, rstn, fast_req, blk_req, data_valid, memory_full, brd_ready;
	logic [1:0]  fast_kind, b_kind;
	logic [7:0]  fast_word, dcnt, b_word;
	logic [4:0]  b_addr;
	logic [14:0] fv_cap;
	logic [15:0] blk_type, blk_sel, blk_len, data_word, b_baddr, b_btype, b_data;
	logic        h_fready, h_bready, h_dready, h_mfull, h_busy, h_crc;
	logic        b_fv, b_bv, b_err, b_gap, c_fv, c_err;
	int          n_fail, num_checks, n_fv, n_err, n_gap, c_nfv, c_nerr;
	logic [15:0] got[$];
	// Check word deliberately wrong
	localparam logic [15:0] BAD [5] = '{16'h0002, 16'h0000, 16'h0004, 16'h0000, 16'h0000};

	command_link_if lnk();
	command_link_if lnk2();
	link_aggregator_end i_link_aggregator_end (.CLOCK(clock), .RSTN(rstn), .LNK(lnk),
		.FAST_REQ(fast_req), .FAST_KIND(fast_kind), .FAST_WORD(fast_word),
		.FAST_READY(h_fready), .BLK_REQ(blk_req), .BLK_TYPE(blk_type), .BLK_SEL(blk_sel),
		.BLK_LEN(blk_len), .BLK_READY(h_bready), .DATA_VALID(data_valid),
		.DATA_WORD(data_word), .DATA_READY(h_dready), .MEM_FULL(h_mfull), .BUSY(h_busy),
		.CRC_ERROR(h_crc));
	link_board_end i_link_board_end (.CLOCK(clock), .RSTN(rstn), .LNK(lnk),
		.MEMORY_FULL(memory_full), .FAST_VALID(b_fv), .FAST_KIND(b_kind),
		.FAST_WORD(b_word), .FAST_ADDR(b_addr), .BLK_VALID(b_bv), .BLK_READY(brd_ready),
		.BLK_ADDR(b_baddr), .BLK_TYPE(b_btype), .BLK_DATA(b_data), .BLK_ERROR(b_err),
		.SEQ_GAP(b_gap));
	// Second board end fed by a hand-driven link carrying faults
	link_board_end i_link_board_end_b (.CLOCK(clock), .RSTN(rstn), .LNK(lnk2),
		.MEMORY_FULL(1'b0), .FAST_VALID(c_fv), .FAST_KIND(), .FAST_WORD(), .FAST_ADDR(),
		.BLK_VALID(), .BLK_READY(1'b1), .BLK_ADDR(), .BLK_TYPE(), .BLK_DATA(),
		.BLK_ERROR(c_err), .SEQ_GAP());
	command_link_monitor i_command_link_monitor (.CLOCK(clock), .RSTN(rstn),
		.link_clk(lnk.link_clk), .down_sym(lnk.down_sym), .down_k(lnk.down_k));

	// ==========================================================
	// Helpers
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	assign data_word = {8'hc3, dcnt};
	// Board drain stalls every other cycle
	always @(posedge clock) begin
		brd_ready <= ~brd_ready;
		if (h_dready === 1'b1)
			dcnt <= dcnt + 8'h01;
	end
	always @(negedge clock) begin
		if (b_bv === 1'b1 && brd_ready === 1'b1)
			got.push_back(b_data);
		if (b_fv === 1'b1)
			fv_cap = {b_kind, b_word, b_addr};
		n_fv += int'(b_fv === 1'b1);
		n_err += int'(b_err === 1'b1);
		n_gap += int'(b_gap === 1'b1);
		c_nfv += int'(c_fv === 1'b1);
		c_nerr += int'(c_err === 1'b1);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic fast(input logic [1:0] k, input logic [7:0] w);
		int f0;
		f0 = n_fv;
		@(posedge clock);
		fast_req <= 1'b1;
		fast_kind <= k;
		fast_word <= w;
		@(negedge clock);
		for (int n = 0; n < 400 && h_fready !== 1'b1; n++)
			@(negedge clock);
		@(posedge clock);
		fast_req <= 1'b0;
		for (int n = 0; n < 200 && n_fv == f0; n++)
			@(negedge clock);
		chk(n_fv - f0, 1);
		chk(fv_cap, {((k == 2'h3) ? 2'h1 : k), w, w[7:3]});
	endtask
	task automatic blk(input logic [15:0] t, s, l, input int errs, gaps);
		logic [7:0] base;
		int e0, g0;
		e0 = n_err;
		g0 = n_gap;
		got.delete();
		@(posedge clock);
		blk_req <= 1'b1;
		blk_type <= t;
		blk_sel <= s;
		blk_len <= l;
		@(negedge clock);
		for (int n = 0; n < 400 && h_bready !== 1'b1; n++)
			@(negedge clock);
		base = dcnt;
		@(posedge clock);
		blk_req <= 1'b0;
		repeat ((2 * int'(l) + 15) * 8) @(negedge clock);
		for (int n = 0; n < 300 && h_busy !== 1'b0; n++)
			@(negedge clock);
		chk(h_busy, 1'b0);
		chk(n_err - e0, errs);
		chk(n_gap - g0, gaps);
		if (errs == 0) begin
			chk(got.size(), l);
			chk({b_baddr, b_btype}, {s, t});
			foreach (got[i])
				chk(got[i], {8'hc3, base + i[7:0]});
		end
	endtask
	// One symbol per 8 clocks: change with the falling link clock, rise 4 later
	task automatic sym(input logic k, input logic [7:0] s);
		@(posedge clock);
		lnk2.down_k   <= k;
		lnk2.down_sym <= s;
		lnk2.link_clk <= 1'b0;
		repeat (4) @(posedge clock);
		lnk2.link_clk <= 1'b1;
		repeat (3) @(posedge clock);
	endtask

	// ==========================================================
	// Tests
	initial begin
		#500000;
		n_fail++;
		wrap_up();
	end
	initial begin
		{rstn, fast_req, blk_req, memory_full, brd_ready} = 5'h00;
		{fast_kind, fast_word, blk_type, blk_sel, blk_len, dcnt} = '0;
		data_valid = 1'b1;
		lnk2.link_clk = 1'b0;
		lnk2.down_sym = 8'he5;
		lnk2.down_k = 1'b1;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		fast(2'h0, 8'h00);
		fast(2'h1, 8'h09);
		fast(2'h2, 8'hff);
		fast(2'h3, 8'h5a);
		blk(16'h0012, 16'h0021, 16'd3, 0, 0);
		blk(16'hf002, 16'hbeef, 16'd0, 0, 0);
		blk(16'h0101, 16'h0007, 16'd16, 0, 0);
		blk(16'h0001, 16'h0007, 16'd17, 1, 0);
		chk(h_crc, 1'b1);
		blk(16'h0080, 16'h0003, 16'd1, 0, 1);
		chk(h_crc, 1'b0);
		@(posedge clock);
		memory_full <= 1'b1;
		for (int n = 0; n < 50 && h_mfull !== 1'b1; n++)
			@(negedge clock);
		chk(h_mfull, 1'b1);
		repeat (40) begin
			@(negedge clock);
			chk(h_bready, 1'b0);
		end
		@(posedge clock);
		memory_full <= 1'b0;
		sym(1'b1, 8'hdf);
		foreach (BAD[i]) begin
			sym(1'b0, BAD[i][15:8]);
			sym(1'b0, BAD[i][7:0]);
		end
		sym(1'b1, 8'hef);
		sym(1'b1, 8'hbf);
		sym(1'b1, 8'hbf);
		chk(c_nerr, 1);
		chk(lnk2.up_crc_err, 1'b1);
		// Frame cut short by an idle comma must be rejected too
		sym(1'b1, 8'hdf);
		sym(1'b0, 8'h00);
		sym(1'b1, 8'he5);
		sym(1'b1, 8'he7);
		sym(1'b0, 8'h09);
		chk(c_nerr, 2);
		chk(c_nfv, 0);
		sym(1'b1, 8'he3);
		sym(1'b0, 8'h61);
		sym(1'b1, 8'he5);
		sym(1'b0, 8'h2e);
		chk(c_nfv, 1);
		wrap_up();
	end
endmodule // test_command_link_framer
